/* ssb_pkg.sv */
// Package for the channel status and user bit register group, plus its byte buffer.
// Assumes one system clock and the serial control port already decoded to byte accesses.
package ssb_pkg;

    // Register port geometry
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    // Register map (byte addresses of the serial control port)
    localparam logic [6:0] ADDR_MUTE_EMPH = 7'h1e;
    localparam logic [6:0] ADDR_NONAUDIO  = 7'h1f;
    localparam logic [6:0] ADDR_RX_CS     = 7'h20;
    localparam logic [6:0] ADDR_TX_CS     = 7'h38;
    localparam logic [6:0] ADDR_UB_PTR    = 7'h50;
    localparam logic [6:0] ADDR_UB_WIN    = 7'h51;

    // Buffer geometry
    localparam int CS_DEPTH = 24;
    localparam int CS_IDX_W = 5;
    localparam int UB_DEPTH = 256;
    localparam int UB_IDX_W = 8;

    // Mute and emphasis control fields
    localparam int BIT_SILENCE = 5;
    localparam int BIT_EMPH_LO = 1;
    localparam int EMPH_W      = 2;

    // Non-audio detect status fields
    localparam int BIT_MC_PREAMBLE = 3;
    localparam int BIT_NA_FRAME    = 2;
    localparam int BIT_NA_SUB_A    = 1;
    localparam int BIT_NA_SUB_B    = 0;
    localparam int NA_W            = 4;

    // Reset values and professional-use flag position
    localparam logic [7:0] MUTE_EMPH_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;
    localparam int         PRO_BYTE        = 0;
    localparam int         PRO_BIT         = 0;

    // De-emphasis curve codes, in field order
    typedef enum logic [1:0] {
        SSB_EMPH_NONE,
        SSB_EMPH_32K,
        SSB_EMPH_44K1,
        SSB_EMPH_48K
    } ssb_emph_t;

    // True when addr falls inside a window of depth bytes starting at base
    function automatic logic ssb_in_window(input logic [6:0] addr, input logic [6:0] base,
                                           input int depth);
        ssb_in_window = (addr >= base) && ({25'h0, addr} < {25'h0, base} + depth);
    endfunction

    // Offset of addr inside a window, zero-extended to eight bits; callers trim it to the index width
    function automatic logic [7:0] ssb_offset(input logic [6:0] addr, input logic [6:0] base);
        ssb_offset = {1'b0, addr - base};
    endfunction

endpackage

/* ssb_byte_buffer.sv */
// Byte buffer held in flip-flops, with a hardware write port and a host write port.
// Assumes both writers are synchronous to clk; the whole array is visible to the parent.
`timescale 1ns/1ps
module ssb_byte_buffer
    import ssb_pkg::*;
#(
    parameter int DEPTH = 24,
    parameter int IDX_W = 5
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Hardware writer
    input  wire logic                    hw_we,
    input  wire logic [IDX_W-1:0]        hw_idx,
    input  wire logic [7:0]              hw_data,
    // Host writer, already gated by the parent
    input  wire logic                    host_we,
    input  wire logic [IDX_W-1:0]        host_idx,
    input  wire logic [7:0]              host_data,
    // Whole contents
    output logic      [DEPTH-1:0][7:0]   mem
);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } ssb_buf_state_t;

    ssb_buf_state_t s_q;
    ssb_buf_state_t s_d;

    // Host write first so that a colliding hardware write to the same byte wins
    always_comb begin
        s_d = s_q;
        if (host_we && (int'(host_idx) < DEPTH)) begin
            s_d.mem[host_idx] = host_data;
        end
        if (hw_we && (int'(hw_idx) < DEPTH)) begin
            s_d.mem[hw_idx] = hw_data;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign mem = s_q.mem;

endmodule

/* ssb_regs.sv */
// Register group for the digital audio transceiver: transmitter mute, converter
// de-emphasis, non-audio detect flags, channel status buffers and user bit window.
// Assumes the serial control port delivers one-cycle byte read/write strobes on REF_CLK,
// and that the autocopy/autobuffer enables come from configuration registers elsewhere.
//
// Behaviour
// [RULE1] Silence bit set mutes the transmitter; clear lets it send normally.
// [RULE2] Two-bit emphasis select picks none, 32, 44.1 or 48 kHz de-emphasis.
// [RULE3] Status bit 3 reports the multichannel CD-audio preamble detection.
// [RULE4] Status bit 2 reports non-audio frame data, either framing standard.
// [RULE5] Status bit 1 reports subframe non-audio data on channel A.
// [RULE6] Status bit 0 reports subframe non-audio data on channel B.
// [RULE7] Received channel status appears as 24 bytes at 0x20 through 0x37.
// [RULE8] Received professional-use flag lives at 0x20 bit 0.
// [RULE9] Received channel status is read-only unless autocopy to transmitter is on.
// [RULE10] Transmitted channel status is 24 bytes at 0x38 through 0x4f.
// [RULE11] Transmitted professional-use flag lives at 0x38 bit 0.
// [RULE12] Autocopy enabled disables the host-written transmitted channel status buffer; the code still takes TX_PROFESSIONAL_USE_FLAG from it.
// [RULE13] Pointer at 0x50 selects the user bit buffer location for the window.
// [RULE14] Reading window 0x51 returns the user byte at the pointer.
// [RULE15] User bit buffer takes host writes only while autobuffering is enabled.
// [RULE16] Muted transmitter keeps framing but sends zero audio samples.
`timescale 1ns/1ps
module ssb_regs
    import ssb_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    // Clock and reset
    input  wire logic                  REF_CLK,
    input  wire logic                  RST_N,
    // Serial control port, decoded
    input  wire logic [ADDR_W-1:0]     REG_ADDR,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    input  wire logic [DATA_W-1:0]     REG_WDATA,
    output logic      [DATA_W-1:0]     REG_RDATA,
    // Mode enables from other configuration registers
    input  wire logic                  CS_AUTOCOPY_EN,
    input  wire logic                  UB_AUTOBUF_EN,
    // Receiver detectors
    input  wire logic                  RX_MC_PREAMBLE,
    input  wire logic                  RX_NONAUDIO_FRAME,
    input  wire logic                  RX_NONAUDIO_SUB_A,
    input  wire logic                  RX_NONAUDIO_SUB_B,
    // Receiver buffer fill
    input  wire logic                  RX_CS_WE,
    input  wire logic [CS_IDX_W-1:0]   RX_CS_IDX,
    input  wire logic [7:0]            RX_CS_DATA,
    input  wire logic                  RX_UB_WE,
    input  wire logic [UB_IDX_W-1:0]   RX_UB_IDX,
    input  wire logic [7:0]            RX_UB_DATA,
    // Transmitter side
    input  wire logic [CS_IDX_W-1:0]   TX_CS_IDX,
    output logic      [7:0]            TX_CS_BYTE,
    input  wire logic [SAMPLE_W-1:0]   TX_SAMPLE_IN,
    output logic      [SAMPLE_W-1:0]   TX_SAMPLE_OUT,
    output logic                       TX_SILENCE,
    output logic                       TX_PROFESSIONAL_USE_FLAG,
    output logic                       RX_PROFESSIONAL_USE_FLAG,
    // Sample rate converter input
    output logic      [EMPH_W-1:0]     CONVERTER_EMPHASIS_FILTER_SELECT
);

    typedef struct packed {
        logic                  transmitter_silence;
        ssb_emph_t             emph;
        logic [NA_W-1:0]       na_status;
        logic [7:0]            rx_userbit_pointer;
        logic [DATA_W-1:0]     rdata;
        logic [SAMPLE_W-1:0]   tx_sample;
        logic [7:0]            tx_cs_byte;
    } ssb_state_t;

    ssb_state_t s_q;
    ssb_state_t s_d;

    logic [CS_DEPTH-1:0][7:0] rx_cs_mem;
    logic [CS_DEPTH-1:0][7:0] tx_cs_mem;
    logic [UB_DEPTH-1:0][7:0] ub_mem;

    logic                     hit_rx_cs;
    logic                     hit_tx_cs;
    logic [7:0]               rx_cs_off;
    logic [7:0]               tx_cs_off;
    logic                     rx_cs_host_we;
    logic                     tx_cs_host_we;
    logic                     ub_host_we;
    logic [7:0]               ctrl_image;

    // Window decode shared by reads and writes
    assign hit_rx_cs = ssb_in_window(REG_ADDR, ADDR_RX_CS, CS_DEPTH);
    assign hit_tx_cs = ssb_in_window(REG_ADDR, ADDR_TX_CS, CS_DEPTH);
    assign rx_cs_off = ssb_offset(REG_ADDR, ADDR_RX_CS);
    assign tx_cs_off = ssb_offset(REG_ADDR, ADDR_TX_CS);

    // [RULE9] Received status host gate
    assign rx_cs_host_we = REG_WR && hit_rx_cs && CS_AUTOCOPY_EN;
    // [RULE12] Transmit buffer locked out
    assign tx_cs_host_we = REG_WR && hit_tx_cs && !CS_AUTOCOPY_EN;
    // [RULE15] User buffer host gate
    assign ub_host_we = REG_WR && (REG_ADDR == ADDR_UB_WIN) && UB_AUTOBUF_EN;

    // Readback image of the control register, unused bits read as zero
    always_comb begin
        ctrl_image = BYTE_ZERO;
        ctrl_image[BIT_SILENCE] = s_q.transmitter_silence;
        ctrl_image[BIT_EMPH_LO +: EMPH_W] = s_q.emph;
    end

    // [RULE7] Received status buffer
    ssb_byte_buffer #(
        .DEPTH (CS_DEPTH),
        .IDX_W (CS_IDX_W)
    ) u_rx_cs (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .hw_we     (RX_CS_WE),
        .hw_idx    (RX_CS_IDX),
        .hw_data   (RX_CS_DATA),
        .host_we   (rx_cs_host_we),
        .host_idx  (rx_cs_off[CS_IDX_W-1:0]),
        .host_data (REG_WDATA),
        .mem       (rx_cs_mem)
    );

    // [RULE10] Transmitted status buffer, host is its only writer
    ssb_byte_buffer #(
        .DEPTH (CS_DEPTH),
        .IDX_W (CS_IDX_W)
    ) u_tx_cs (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .hw_we     (1'b0),
        .hw_idx    ('0),
        .hw_data   (BYTE_ZERO),
        .host_we   (tx_cs_host_we),
        .host_idx  (tx_cs_off[CS_IDX_W-1:0]),
        .host_data (REG_WDATA),
        .mem       (tx_cs_mem)
    );

    // [RULE15] Received user bit buffer, written through the window
    ssb_byte_buffer #(
        .DEPTH (UB_DEPTH),
        .IDX_W (UB_IDX_W)
    ) u_rx_ub (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .hw_we     (RX_UB_WE),
        .hw_idx    (RX_UB_IDX),
        .hw_data   (RX_UB_DATA),
        .host_we   (ub_host_we),
        .host_idx  (s_q.rx_userbit_pointer),
        .host_data (REG_WDATA),
        .mem       (ub_mem)
    );

    // Next-state logic: control writes, status capture, readback and transmit feed
    always_comb begin
        s_d = s_q;
        // [RULE3] Preamble flag capture
        s_d.na_status[BIT_MC_PREAMBLE] = RX_MC_PREAMBLE;
        // [RULE4] Non-audio frame capture
        s_d.na_status[BIT_NA_FRAME] = RX_NONAUDIO_FRAME;
        // [RULE5] Channel A subframe capture
        s_d.na_status[BIT_NA_SUB_A] = RX_NONAUDIO_SUB_A;
        // [RULE6] Channel B subframe capture
        s_d.na_status[BIT_NA_SUB_B] = RX_NONAUDIO_SUB_B;

        if (REG_WR && (REG_ADDR == ADDR_MUTE_EMPH)) begin
            // [RULE1] Silence bit write
            s_d.transmitter_silence = REG_WDATA[BIT_SILENCE];
            // [RULE2] Emphasis select write
            s_d.emph = ssb_emph_t'(REG_WDATA[BIT_EMPH_LO +: EMPH_W]);
        end
        if (REG_WR && (REG_ADDR == ADDR_UB_PTR)) begin
            // [RULE13] Pointer write
            s_d.rx_userbit_pointer = REG_WDATA;
        end

        // Read data holds until the next read; unmapped addresses return zero
        if (REG_RD) begin
            s_d.rdata = BYTE_ZERO;
            if (REG_ADDR == ADDR_MUTE_EMPH) begin
                s_d.rdata = ctrl_image;
            end else if (REG_ADDR == ADDR_NONAUDIO) begin
                s_d.rdata = {{(DATA_W-NA_W){1'b0}}, s_q.na_status};
            end else if (hit_rx_cs) begin
                s_d.rdata = rx_cs_mem[rx_cs_off[CS_IDX_W-1:0]];
            end else if (hit_tx_cs) begin
                s_d.rdata = tx_cs_mem[tx_cs_off[CS_IDX_W-1:0]];
            end else if (REG_ADDR == ADDR_UB_PTR) begin
                s_d.rdata = s_q.rx_userbit_pointer;
            end else if (REG_ADDR == ADDR_UB_WIN) begin
                // [RULE14] Window read
                s_d.rdata = ub_mem[s_q.rx_userbit_pointer];
            end
        end

        // [RULE12] Autocopy feeds the transmit status byte from the receiver
        if (CS_AUTOCOPY_EN) begin
            s_d.tx_cs_byte = rx_cs_mem[TX_CS_IDX];
        end else begin
            s_d.tx_cs_byte = tx_cs_mem[TX_CS_IDX];
        end

        // [RULE16] Zero samples while silent; framing is left to the encoder
        if (s_q.transmitter_silence) begin
            s_d.tx_sample = '0;
        end else begin
            s_d.tx_sample = TX_SAMPLE_IN;
        end
    end

    // State register
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q                     <= '0;
            s_q.transmitter_silence <= MUTE_EMPH_RESET[BIT_SILENCE];
            s_q.emph                <= ssb_emph_t'(MUTE_EMPH_RESET[BIT_EMPH_LO +: EMPH_W]);
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign REG_RDATA                        = s_q.rdata;
    assign TX_CS_BYTE                       = s_q.tx_cs_byte;
    assign TX_SAMPLE_OUT                    = s_q.tx_sample;
    // [RULE1] Silence drives the transmitter
    assign TX_SILENCE                       = s_q.transmitter_silence;
    // [RULE2] Curve select to the converter
    assign CONVERTER_EMPHASIS_FILTER_SELECT = s_q.emph;
    // [RULE8] Received professional flag
    assign RX_PROFESSIONAL_USE_FLAG         = rx_cs_mem[PRO_BYTE][PRO_BIT];
    // [RULE11] Transmitted professional flag
    assign TX_PROFESSIONAL_USE_FLAG         = tx_cs_mem[PRO_BYTE][PRO_BIT];

    // Silence write reaches the transmitter one edge later
    AST_SILENCE_WRITE: assert property ( // [RULE1]
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == ADDR_MUTE_EMPH)
            |=> TX_SILENCE == $past(REG_WDATA[BIT_SILENCE]))
        else $error("silence bit did not follow the control write");

    // Emphasis field follows the written value
    AST_EMPH_WRITE: assert property ( // [RULE2]
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == ADDR_MUTE_EMPH)
            |=> CONVERTER_EMPHASIS_FILTER_SELECT == $past(REG_WDATA[BIT_EMPH_LO +: EMPH_W]))
        else $error("emphasis select did not follow the control write");

    // Detector levels show in the status read two edges after they are seen
    AST_STATUS_READ: assert property ( // [RULE4]
        @(posedge REF_CLK) disable iff (!RST_N)
        ($past(REG_RD) && $past(REG_ADDR) == ADDR_NONAUDIO)
            |-> REG_RDATA == {4'h0, $past(RX_MC_PREAMBLE, 2), $past(RX_NONAUDIO_FRAME, 2),
                              $past(RX_NONAUDIO_SUB_A, 2), $past(RX_NONAUDIO_SUB_B, 2)})
        else $error("non-audio status read does not match detectors");

    // Host write to the received buffer without autocopy leaves it unchanged
    AST_RXCS_LOCKED: assert property ( // [RULE9]
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_WR && hit_rx_cs && !CS_AUTOCOPY_EN && !RX_CS_WE) |=> $stable(rx_cs_mem))
        else $error("received status buffer took a host write while locked");

    // Host write to the transmitted buffer under autocopy leaves it unchanged
    AST_TXCS_DISABLED: assert property ( // [RULE12]
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_WR && hit_tx_cs && CS_AUTOCOPY_EN) |=> $stable(tx_cs_mem))
        else $error("transmitted status buffer took a host write under autocopy");

    // Under steady autocopy the transmitter sees received bytes
    AST_TXCS_SOURCE: assert property ( // [RULE12]
        @(posedge REF_CLK) disable iff (!RST_N)
        CS_AUTOCOPY_EN |=> TX_CS_BYTE == $past(rx_cs_mem[TX_CS_IDX]))
        else $error("transmit status byte not taken from the receiver under autocopy");

    // Host byte written to the transmitted buffer reads back after one idle cycle
    AST_TXCS_READBACK: assert property ( // [RULE10]
        @(posedge REF_CLK) disable iff (!RST_N)
        (tx_cs_host_we ##1 !REG_WR ##1 (REG_RD && REG_ADDR == $past(REG_ADDR, 2)))
            |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("transmitted status byte did not read back");

    // Window read returns the user byte at the current pointer
    AST_WINDOW_READ: assert property ( // [RULE14]
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_RD && REG_ADDR == ADDR_UB_WIN) |=> REG_RDATA == $past(ub_mem[s_q.rx_userbit_pointer]))
        else $error("window read returned the wrong user byte");

    // Pointer takes the written value
    AST_POINTER_WRITE: assert property ( // [RULE13]
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == ADDR_UB_PTR) |=> s_q.rx_userbit_pointer == $past(REG_WDATA))
        else $error("user bit pointer did not take the written value");

    // Window write without autobuffering leaves the user buffer alone
    AST_UB_LOCKED: assert property ( // [RULE15]
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == ADDR_UB_WIN && !UB_AUTOBUF_EN && !RX_UB_WE) |=> $stable(ub_mem))
        else $error("user bit buffer took a host write while read-only");

    // Two silent cycles give zero samples on the second
    AST_MUTE_ZERO: assert property ( // [RULE16]
        @(posedge REF_CLK) disable iff (!RST_N)
        TX_SILENCE [*2] |-> TX_SAMPLE_OUT == '0)
        else $error("muted transmitter passed a non-zero sample");

    // Unmuted samples pass through with one cycle of delay
    AST_UNMUTE_PASS: assert property ( // [RULE1]
        @(posedge REF_CLK) disable iff (!RST_N)
        !TX_SILENCE |=> TX_SAMPLE_OUT == $past(TX_SAMPLE_IN))
        else $error("unmuted transmitter did not pass the sample");

    // Received professional flag mirrors byte zero bit zero of the received buffer
    AST_PRO_FLAGS: assert property ( // [RULE8]
        @(posedge REF_CLK) disable iff (!RST_N)
        (RX_CS_WE && RX_CS_IDX == '0) |=> RX_PROFESSIONAL_USE_FLAG == $past(RX_CS_DATA[PRO_BIT]))
        else $error("received professional flag not at byte zero bit zero");

    // Receiver fill lands at its byte inside the received buffer
    AST_RXCS_FILL: assert property ( // [RULE7]
        @(posedge REF_CLK) disable iff (!RST_N)
        (RX_CS_WE && int'(RX_CS_IDX) < CS_DEPTH)
            |=> rx_cs_mem[$past(RX_CS_IDX)] == $past(RX_CS_DATA))
        else $error("receiver fill did not land in the received status buffer");

    // Under autocopy a host byte lands in the received buffer
    AST_RXCS_OPEN: assert property ( // [RULE9]
        @(posedge REF_CLK) disable iff (!RST_N)
        (rx_cs_host_we && !RX_CS_WE)
            |=> rx_cs_mem[$past(rx_cs_off[CS_IDX_W-1:0])] == $past(REG_WDATA))
        else $error("received status buffer refused a host write under autocopy");

    // Transmitted professional flag follows a host write to byte zero
    AST_TX_PRO_FLAG: assert property ( // [RULE11]
        @(posedge REF_CLK) disable iff (!RST_N)
        (tx_cs_host_we && tx_cs_off == 8'(PRO_BYTE))
            |=> TX_PROFESSIONAL_USE_FLAG == $past(REG_WDATA[PRO_BIT]))
        else $error("transmitted professional flag not at byte zero bit zero");

    // With autobuffering on, a window write lands at the pointed location
    AST_UB_OPEN: assert property ( // [RULE15]
        @(posedge REF_CLK) disable iff (!RST_N)
        (ub_host_we && !RX_UB_WE)
            |=> ub_mem[$past(s_q.rx_userbit_pointer)] == $past(REG_WDATA))
        else $error("user bit buffer refused a window write under autobuffering");

endmodule

/* ssb_host_model.sv */
// Host controller model for the serial control port of the register group.
// Assumes decoded byte strobes; one access per two cycles, launched 1 ns after an edge.
`timescale 1ns/1ps
module ssb_host_model
    import ssb_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Decoded control port
    output logic [ADDR_W-1:0]      reg_addr,
    output logic                   reg_wr,
    output logic                   reg_rd,
    output logic [DATA_W-1:0]      reg_wdata
);
    // Idle bus at time zero
    initial begin
        reg_addr  = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = '0;
    end

    // One strobe cycle; released lines show the inverse so stale values never match
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = ~w;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule

/* testbench.sv */
// Self-checking bench for the channel status and user bit register group.
// Assumes the host model is the only control port master; reads are scored from a queue.
`timescale 1ns/1ps
module testbench;
    import ssb_pkg::*;
    logic                ref_clk, rst_n, reg_wr, reg_rd, rd_q = 1'b0;
    logic [ADDR_W-1:0]   reg_addr;
    logic [7:0]          reg_wdata, reg_rdata, tx_cs_byte, rx_cs_data, rx_ub_data;
    logic                autocopy, autobuf, rx_cs_we, rx_ub_we, tx_silence, tx_pro, rx_pro;
    logic [3:0]          det;
    logic [4:0]          rx_cs_idx, tx_cs_idx;
    logic [7:0]          rx_ub_idx, v, d0, d23, t0, t23, ix;
    logic [23:0]         s_in, s_out;
    logic [1:0]          emph;
    logic [7:0]          exp_q[$];
    int                  fails = 0, checks = 0, seed;

    ssb_host_model i_ssb_host_model (.clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    ssb_regs #(.SAMPLE_W(24)) i_ssb_regs (.REF_CLK(ref_clk), .RST_N(rst_n),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .CS_AUTOCOPY_EN(autocopy), .UB_AUTOBUF_EN(autobuf),
        .RX_MC_PREAMBLE(det[3]), .RX_NONAUDIO_FRAME(det[2]), .RX_NONAUDIO_SUB_A(det[1]),
        .RX_NONAUDIO_SUB_B(det[0]), .RX_CS_WE(rx_cs_we), .RX_CS_IDX(rx_cs_idx),
        .RX_CS_DATA(rx_cs_data), .RX_UB_WE(rx_ub_we), .RX_UB_IDX(rx_ub_idx),
        .RX_UB_DATA(rx_ub_data), .TX_CS_IDX(tx_cs_idx), .TX_CS_BYTE(tx_cs_byte),
        .TX_SAMPLE_IN(s_in), .TX_SAMPLE_OUT(s_out), .TX_SILENCE(tx_silence),
        .TX_PROFESSIONAL_USE_FLAG(tx_pro), .RX_PROFESSIONAL_USE_FLAG(rx_pro),
        .CONVERTER_EMPHASIS_FILTER_SELECT(emph));

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Host accesses; a read notes its expected byte first
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_ssb_host_model.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_ssb_host_model.access(1'b0, a, 8'h00);
    endtask

    // Receiver side buffer fill, one-cycle write pulse
    task automatic rx_wr(input logic ub, input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        {rx_ub_we, rx_ub_idx, rx_ub_data} = {ub, idx, d};
        {rx_cs_we, rx_cs_idx, rx_cs_data} = {~ub, idx[4:0], d};
        @(posedge ref_clk);
        #1;
        rx_ub_we = 1'b0;
        rx_cs_we = 1'b0;
    endtask

    // Read data lands one edge after the strobe; scored mid-cycle
    always @(posedge ref_clk) rd_q <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_q && exp_q.size() > 0) begin
            check("rdata", 32'(reg_rdata), 32'(exp_q.pop_front()));
        end
    end

    // Hang guard
    initial begin
        #500000;
        fails++;
        finish_test();
    end

    initial begin
        {rst_n, autocopy, autobuf, det, rx_cs_we, rx_ub_we, tx_cs_idx} = '0;
        {rx_cs_idx, rx_cs_data, rx_ub_idx, rx_ub_data, s_in} = '0;
        seed = $urandom(25304);
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        // Reset values and an unmapped place
        check("silence", 32'(tx_silence), 32'(0));
        rd(ADDR_MUTE_EMPH, 8'h00);
        wr(7'h7f, 8'h5a);
        rd(7'h7f, 8'h00);
        $display("test reset done");
        // Every emphasis code, silence on odd codes, reserved bits written as ones
        for (int e = 0; e < 4; e++) begin
            v = {2'b11, e[0], 2'b11, e[1:0], 1'b1};
            wr(ADDR_MUTE_EMPH, v);
            rd(ADDR_MUTE_EMPH, v & 8'h26);
            check("emph", 32'(emph), 32'(e[1:0]));
            check("silence", 32'(tx_silence), 32'(e[0]));
            s_in = 24'($urandom());
            @(posedge ref_clk);
            #1;
            check("sample", 32'(s_out), 32'(e[0] ? 24'h0 : s_in));
        end
        $display("test control done");
        // All detector combinations; status stays read-only
        wr(ADDR_NONAUDIO, 8'hff);
        for (int s = 0; s < 16; s++) begin
            det = s[3:0];
            repeat (3) @(posedge ref_clk);
            rd(ADDR_NONAUDIO, {4'h0, s[3:0]});
        end
        $display("test status done");
        // Received channel status, first and last byte
        d0 = 8'($urandom());
        d23 = 8'($urandom());
        rx_wr(1'b0, 8'd0, d0);
        rx_wr(1'b0, 8'd23, d23);
        rd(ADDR_RX_CS, d0);
        rd(ADDR_RX_CS + 7'd23, d23);
        check("rx_pro", 32'(rx_pro), 32'(d0[0]));
        wr(ADDR_RX_CS, ~d0);
        rd(ADDR_RX_CS, d0);
        autocopy = 1'b1;
        wr(ADDR_RX_CS, ~d0);
        rd(ADDR_RX_CS, ~d0);
        $display("test rx status done");
        // Transmitted channel status with and without autocopy
        wr(ADDR_TX_CS, 8'h5a);
        autocopy = 1'b0;
        rd(ADDR_TX_CS, 8'h00);
        t0 = 8'($urandom());
        t23 = 8'($urandom());
        wr(ADDR_TX_CS, t0);
        wr(ADDR_TX_CS + 7'd23, t23);
        rd(ADDR_TX_CS + 7'd23, t23);
        rd(ADDR_TX_CS, t0);
        check("tx_pro", 32'(tx_pro), 32'(t0[0]));
        tx_cs_idx = 5'd23;
        repeat (2) @(posedge ref_clk);
        #1;
        check("tx_cs", 32'(tx_cs_byte), 32'(t23));
        autocopy = 1'b1;
        wr(ADDR_TX_CS + 7'd23, ~t23);
        check("tx_cs", 32'(tx_cs_byte), 32'(d23));
        autocopy = 1'b0;
        rd(ADDR_TX_CS + 7'd23, t23);
        $display("test tx status done");
        // User bit window through the pointer, top location first
        for (int k = 0; k < 4; k++) begin
            ix = (k == 0) ? 8'hff : 8'($urandom());
            v = 8'($urandom());
            rx_wr(1'b1, ix, v);
            wr(ADDR_UB_PTR, ix);
            rd(ADDR_UB_PTR, ix);
            rd(ADDR_UB_WIN, v);
            wr(ADDR_UB_WIN, ~v);
            rd(ADDR_UB_WIN, v);
            autobuf = 1'b1;
            wr(ADDR_UB_WIN, ~v);
            rd(ADDR_UB_WIN, ~v);
            autobuf = 1'b0;
        end
        $display("test user bits done");
        for (int n = 0; n < 10 && exp_q.size() > 0; n++) @(posedge ref_clk);
        if (exp_q.size() > 0) fails++;
        finish_test();
    end
endmodule
